// file: design/serial_flash_mode_control.v
// Command decoder and mode state of a serial NOR flash SPI port
//
// Summary of operation
// - Quad enable lives in bit 1 of status register two.
// - Instruction 05h returns status register one.
// - Instruction 35h returns status register two.
// - Write status 01h, second byte bit 1 high sets quad enable.
// - Write status with second byte bit 1 low clears quad enable.
// - Continuous quad read lets later reads skip the instruction byte.
// - Mode bits Axh enter continuous quad read; host sets quad first.
// - Mode bits 00h leave continuous mode after the current read.
// - Eight clocks of all ones on data lines at frame start leave continuous mode.
// - Setting bit 6 of config 800003h via 65h/71h enables quad commands.
// - Clearing bit 6 of config 800003h returns to single-wire commands.
// - Soft reset 66h then 99h leaves four-wire command mode.
// - Instruction B7h selects 4-byte addressing without write enable.
// - Dedicated instructions always take a 4-byte address.
// - Status one bit 0 is the busy bit; busy_r is never set, so it always reads zero.
// - Soft reset pair accepted on 1 or 4 wires per mode.
`timescale 1ns/1ps
`include "sfmc_map.vh"

module serial_flash_mode_control (
  // System
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // SPI link from host
  input wire SPI_SCK_I,
  input wire SPI_CS_N_I,
  input wire [3:0] SPI_DQ_I,
  output reg [3:0] SPI_DQ_O,
  output reg [3:0] SPI_DQ_OE_O,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire PREADY_O,
  output wire PSLVERR_O,
  output reg [31:0] PRDATA_O,
  // Mode status
  output wire QUAD_CMD_MODE_O,
  output wire CONT_READ_O,
  output wire ADDR4_MODE_O
);

  // ==========================================================
  // Phase encoding
  localparam PH_CMD = 3'h0;
  localparam PH_ADDR = 3'h1;
  localparam PH_MODE = 3'h2;
  localparam PH_DUMMY = 3'h3;
  localparam PH_WDATA = 3'h4;
  localparam PH_RDATA = 3'h5;
  localparam PH_IGNORE = 3'h6;

  // Bits shifted per SCK edge in current width
  function [2:0] lane_bits;
    input quad;
    begin
      lane_bits = quad ? 3'h4 : 3'h1;
    end
  endfunction

  // Address byte count for an instruction
  function [2:0] addr_bytes;
    input [7:0] op;
    input a4;
    begin
      case (op)
        `SFMC_OP_RDCFG, `SFMC_OP_WRCFG: addr_bytes = 3'h3;
        `SFMC_OP_QIOR4, `SFMC_OP_READ4, `SFMC_OP_FREAD4,
        `SFMC_OP_PP4, `SFMC_OP_SE4: addr_bytes = 3'h4;
        default: addr_bytes = a4 ? 3'h4 : 3'h3;
      endcase
    end
  endfunction

  // ==========================================================
  // Link synchronisers; first stage read only by the second
  reg [1:0] sck_s_r;
  reg [1:0] cs_s_r;
  reg [3:0] dq_s1_r;
  reg [3:0] dq_s2_r;
  reg sck_d_r;
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sck_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
      sck_d_r <= 1'b0;
    end else begin
      sck_s_r <= {sck_s_r[0], SPI_SCK_I};
      cs_s_r <= {cs_s_r[0], SPI_CS_N_I};
      dq_s1_r <= SPI_DQ_I;
      dq_s2_r <= dq_s1_r;
      sck_d_r <= sck_s_r[1];
    end
  end

  wire cs_act = ~cs_s_r[1];
  wire sck_rise = sck_s_r[1] & ~sck_d_r;
  wire sck_fall = ~sck_s_r[1] & sck_d_r;

  // ==========================================================
  // Mode and register state
  reg [7:0] sr1_r;
  reg [7:0] sr2_r;
  reg [7:0] cfg3_r;
  reg cont_r;
  reg cont_exit_r;
  reg addr4_r;
  reg rsten_r;
  reg busy_r;
  reg [2:0] ph_r;
  reg [7:0] op_r;
  reg [7:0] sh_r;
  reg [5:0] cnt_r;
  reg [2:0] bytes_r;
  reg [23:0] addr_r;
  reg [1:0] wcnt_r;
  reg [7:0] wsr1_r;
  reg [3:0] ones_r;
  reg ones_ok_r;
  reg frame_q_r;
  reg [7:0] tx_r;
  reg quad_io_r;

  wire quad_cmd = cfg3_r[`SFMC_QUADCMD_BIT];
  wire quad_en = sr2_r[`SFMC_QUAD_EN_BIT];

  // Width of the current phase
  always @* begin
    case (ph_r)
      PH_CMD: quad_io_r = quad_cmd;
      PH_ADDR, PH_MODE, PH_DUMMY:
        quad_io_r = quad_cmd | op_r == `SFMC_OP_QIOR |
                    op_r == `SFMC_OP_QIOR4;
      default: quad_io_r = quad_cmd;
    endcase
  end

  wire [2:0] lb = lane_bits(quad_io_r);
  wire [7:0] sh_in = quad_io_r ? {sh_r[3:0], dq_s2_r} :
                     {sh_r[6:0], dq_s2_r[0]};
  wire [5:0] cnt_in = cnt_r + {3'h0, lb};
  wire byte_done = cnt_in[3];

  // Read-back byte for the instruction in progress
  function [7:0] read_byte;
    input [7:0] op;
    input [7:0] s1;
    input [7:0] s2;
    input [7:0] c3;
    begin
      case (op)
        `SFMC_OP_RDSR1: read_byte = s1;
        `SFMC_OP_RDSR2: read_byte = s2;
        `SFMC_OP_RDCFG: read_byte = c3;
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // Frame decoder on sampled SCK edges
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sr1_r <= `SFMC_SR1_RST;
      sr2_r <= `SFMC_SR2_RST;
      cfg3_r <= `SFMC_CFG3_RST;
      cont_r <= 1'b0;
      cont_exit_r <= 1'b0;
      addr4_r <= 1'b0;
      rsten_r <= 1'b0;
      busy_r <= 1'b0;
      ph_r <= PH_CMD;
      op_r <= 8'h00;
      sh_r <= 8'h00;
      cnt_r <= 6'h00;
      bytes_r <= 3'h0;
      addr_r <= 24'h000000;
      wcnt_r <= 2'h0;
      wsr1_r <= 8'h00;
      ones_r <= 4'h0;
      ones_ok_r <= 1'b0;
      frame_q_r <= 1'b0;
      tx_r <= 8'h00;
    end else begin
      frame_q_r <= cs_act;
      if (!cs_act) begin
        // Frame end: commit status writes and exits
        if (frame_q_r) begin
          if (op_r == `SFMC_OP_WRSR && wcnt_r == 2'h2) begin
            sr1_r <= {wsr1_r[7:1], sr1_r[`SFMC_BUSY_BIT]};
            sr2_r[`SFMC_QUAD_EN_BIT] <= sh_r[`SFMC_QUAD_EN_BIT];
          end
          if (cont_exit_r) begin
            cont_r <= 1'b0;
          end
          if (ones_ok_r) begin
            cont_r <= 1'b0;
          end
        end
        cont_exit_r <= 1'b0;
        ones_r <= 4'h0;
        ones_ok_r <= 1'b0;
        cnt_r <= 6'h00;
        wcnt_r <= 2'h0;
        // Continuous read skips straight to the address
        if (cont_r && !ones_ok_r && !cont_exit_r) begin
          ph_r <= PH_ADDR;
          bytes_r <= addr_bytes(op_r, addr4_r);
        end else begin
          ph_r <= PH_CMD;
        end
      end else if (sck_rise) begin
        // Mode bit reset: all ones held on every lane
        if (dq_s2_r == 4'hF && ones_r != `SFMC_MODE_RST_CLKS) begin
          ones_r <= ones_r + 4'h1;
          if (ones_r == `SFMC_MODE_RST_CLKS - 4'h1) begin
            ones_ok_r <= 1'b1;
          end
        end else if (dq_s2_r != 4'hF) begin
          ones_r <= `SFMC_MODE_RST_CLKS;
        end
        sh_r <= sh_in;
        cnt_r <= byte_done ? 6'h00 : cnt_in;
        if (byte_done) begin
          case (ph_r)
            PH_CMD: begin
              op_r <= sh_in;
              rsten_r <= sh_in == `SFMC_OP_RSTEN;
              bytes_r <= addr_bytes(sh_in, addr4_r);
              addr_r <= 24'h000000;
              tx_r <= read_byte(sh_in, sr1_r, sr2_r, cfg3_r);
              case (sh_in)
                `SFMC_OP_RST: begin
                  if (rsten_r) begin
                    cfg3_r <= `SFMC_CFG3_RST;
                    addr4_r <= 1'b0;
                    cont_r <= 1'b0;
                  end
                  ph_r <= PH_IGNORE;
                end
                `SFMC_OP_EN4B: begin
                  addr4_r <= 1'b1;
                  ph_r <= PH_IGNORE;
                end
                `SFMC_OP_RDSR1, `SFMC_OP_RDSR2: ph_r <= PH_RDATA;
                `SFMC_OP_WRSR: ph_r <= PH_WDATA;
                `SFMC_OP_RDCFG, `SFMC_OP_WRCFG, `SFMC_OP_QIOR,
                `SFMC_OP_QIOR4, `SFMC_OP_READ4, `SFMC_OP_FREAD4,
                `SFMC_OP_PP4, `SFMC_OP_SE4: ph_r <= PH_ADDR;
                default: ph_r <= PH_IGNORE;
              endcase
            end
            PH_ADDR: begin
              addr_r <= {addr_r[15:0], sh_in};
              bytes_r <= bytes_r - 3'h1;
              if (bytes_r == 3'h1) begin
                if (op_r == `SFMC_OP_QIOR || op_r == `SFMC_OP_QIOR4) begin
                  ph_r <= PH_MODE;
                end else if (op_r == `SFMC_OP_WRCFG) begin
                  ph_r <= PH_WDATA;
                end else if (op_r == `SFMC_OP_RDCFG) begin
                  ph_r <= PH_RDATA;
                end else begin
                  ph_r <= PH_IGNORE;
                end
              end
            end
            PH_MODE: begin
              // Entry needs quad enable already set
              if (sh_in[7:4] == `SFMC_MODE_ENTER_HI && quad_en) begin
                cont_r <= 1'b1;
              end else if (sh_in == `SFMC_MODE_EXIT) begin
                cont_exit_r <= 1'b1;
              end else begin
                cont_exit_r <= 1'b1;
              end
              ph_r <= PH_DUMMY;
            end
            PH_WDATA: begin
              if (op_r == `SFMC_OP_WRSR) begin
                if (wcnt_r == 2'h0) begin
                  wsr1_r <= sh_in;
                end
                if (wcnt_r != 2'h2) begin
                  wcnt_r <= wcnt_r + 2'h1;
                end
              end else if (addr_r == `SFMC_CFG3_ADDR) begin
                cfg3_r <= sh_in;
                ph_r <= PH_IGNORE;
              end else begin
                ph_r <= PH_IGNORE;
              end
            end
            default: ph_r <= ph_r;
          endcase
        end
        // Status reads repeat while the frame stays open
        if (ph_r == PH_RDATA && byte_done) begin
          tx_r <= read_byte(op_r, sr1_r, sr2_r,
                            addr_r == `SFMC_CFG3_ADDR ? cfg3_r : 8'h00);
        end
      end
      busy_r <= 1'b0;
      sr1_r[`SFMC_BUSY_BIT] <= busy_r;
    end
  end

  // ==========================================================
  // Read data shifted out on falling SCK
  reg [5:0] tcnt_r;
  wire [7:0] tx_now = tx_r << tcnt_r[2:0];
  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SPI_DQ_O <= 4'h0;
      SPI_DQ_OE_O <= 4'h0;
      tcnt_r <= 6'h00;
    end else if (!cs_act || ph_r != PH_RDATA) begin
      SPI_DQ_OE_O <= 4'h0;
      tcnt_r <= 6'h00;
    end else if (sck_fall) begin
      if (quad_cmd) begin
        SPI_DQ_O <= tx_now[7:4];
        SPI_DQ_OE_O <= 4'hF;
        tcnt_r <= {3'h0, tcnt_r[2:0] + 3'h4};
      end else begin
        SPI_DQ_O <= {2'h0, tx_now[7], 1'b0};
        SPI_DQ_OE_O <= 4'h2;
        tcnt_r <= {3'h0, tcnt_r[2:0] + 3'h1};
      end
    end
  end

  // ==========================================================
  // APB slave: zero-wait, read-only view of mode state
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign QUAD_CMD_MODE_O = quad_cmd;
  assign CONT_READ_O = cont_r;
  assign ADDR4_MODE_O = addr4_r;

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I)
        `SFMC_STAT_OFS:
          PRDATA_O <= {29'h0, addr4_r, cont_r, quad_cmd};
        `SFMC_SR1_OFS: PRDATA_O <= {24'h0, sr1_r};
        `SFMC_SR2_OFS: PRDATA_O <= {24'h0, sr2_r};
        `SFMC_CFG3_OFS: PRDATA_O <= {24'h0, cfg3_r};
        default: PRDATA_O <= 32'h00000000;
      endcase
    end
  end

endmodule

// file: design/sfmc_map.vh
// Constants for the serial flash mode control block
`ifndef SFMC_MAP_VH
`define SFMC_MAP_VH
// APB register offsets
`define SFMC_CTRL_OFS 12'h000
`define SFMC_STAT_OFS 12'h004
`define SFMC_SR1_OFS 12'h008
`define SFMC_SR2_OFS 12'h00C
`define SFMC_CFG3_OFS 12'h010
// Field positions
`define SFMC_BUSY_BIT 0
`define SFMC_QUAD_EN_BIT 1
`define SFMC_QUADCMD_BIT 6
// Reset values
`define SFMC_SR1_RST 8'h00
`define SFMC_SR2_RST 8'h00
`define SFMC_CFG3_RST 8'h00
// Instructions
`define SFMC_OP_RDSR1 8'h05
`define SFMC_OP_RDSR2 8'h35
`define SFMC_OP_WRSR 8'h01
`define SFMC_OP_RDCFG 8'h65
`define SFMC_OP_WRCFG 8'h71
`define SFMC_OP_RSTEN 8'h66
`define SFMC_OP_RST 8'h99
`define SFMC_OP_EN4B 8'hB7
`define SFMC_OP_QIOR 8'hEB
`define SFMC_OP_QIOR4 8'hEC
`define SFMC_OP_READ4 8'h13
`define SFMC_OP_FREAD4 8'h0C
`define SFMC_OP_PP4 8'h12
`define SFMC_OP_SE4 8'hDC
// Mode bits and address of the volatile configuration byte
`define SFMC_MODE_ENTER_HI 4'hA
`define SFMC_MODE_EXIT 8'h00
`define SFMC_CFG3_ADDR 24'h800003
// Clocks of all-ones that reset the mode bits
`define SFMC_MODE_RST_CLKS 4'h8
// Dummy clocks after mode bits in quad read
`define SFMC_QIOR_DUMMY 4'h4
`endif

// file: test/sfmc_monitor.sv
// Port checker for the serial flash mode control block
`timescale 1ns/1ps
`include "sfmc_map.vh"
// ==========================================================
// Checker
module sfmc_monitor (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // Link
  input wire SPI_CS_N_I,
  input wire [3:0] SPI_DQ_OE_O,
  // APB
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire [31:0] PRDATA_O,
  // Modes
  input wire QUAD_CMD_MODE_O,
  input wire CONT_READ_O,
  input wire ADDR4_MODE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // Read setup cycle at one offset
  sequence s_rd(a);
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == a;
  endsequence
  a_ready_high: assert property (
    PSEL_I |-> PREADY_O && !PSLVERR_O) else $error("bad slave answer");
  a_busy_idle: assert property (
    s_rd(`SFMC_SR1_OFS) |=> !PRDATA_O[0]) else $error("busy bit set");
  a_cfg_mirror: assert property (
    s_rd(`SFMC_CFG3_OFS) |=> PRDATA_O[6] == $past(QUAD_CMD_MODE_O))
    else $error("config bit 6 wrong");
  a_stat_mirror: assert property (
    s_rd(`SFMC_STAT_OFS) |=> PRDATA_O[2:0] == {$past(ADDR4_MODE_O),
    $past(CONT_READ_O), $past(QUAD_CMD_MODE_O)}) else $error("status bad");
  a_rdata_hold: assert property (
    !(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
    else $error("read data moved");
  a_oe_release: assert property (
    $rose(SPI_CS_N_I) |-> ##[1:8] SPI_DQ_OE_O == 4'h0)
    else $error("lines still driven");
  // Entry lands inside the frame, exit only once select is high
  a_cont_at_cs: assert property (
    $changed(CONT_READ_O) |-> SPI_CS_N_I == !CONT_READ_O)
    else $error("mode moved at wrong time");
  a_reset_start: assert property (
    $rose(RST_N_I) |-> !QUAD_CMD_MODE_O && !CONT_READ_O && !ADDR4_MODE_O)
    else $error("modes not clear");
endmodule

bind serial_flash_mode_control sfmc_monitor sfmc_monitor_inst (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .SPI_CS_N_I(SPI_CS_N_I),
  .SPI_DQ_OE_O(SPI_DQ_OE_O), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .PRDATA_O(PRDATA_O),
  .QUAD_CMD_MODE_O(QUAD_CMD_MODE_O), .CONT_READ_O(CONT_READ_O),
  .ADDR4_MODE_O(ADDR4_MODE_O));

// file: test/sfmc_host.sv
// Behavioural host SPI controller facing the flash block
`timescale 1ns/1ps
// ==========================================================
// Host model
module sfmc_host (
  // Bench clock paces every link edge
  input wire logic clk,
  // Wire level seen by the host
  input wire logic [3:0] dq_in,
  // Host-driven link
  output logic sck,
  output logic cs_n,
  output logic [3:0] dq
);
  // Clock idles low between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end
  // One byte, MSB first; quad sends the high nibble first
  // Four bench clocks per half period give the 800 ns link clock
  task automatic xb(input logic [7:0] t, input bit q,
                    output logic [7:0] r);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      dq <= q ? t[7-4*i -: 4] : {~dq[3:1], t[7-i]};
      repeat (4) @(posedge clk);
      // Mode 0 host: read data taken at the rising link edge
      r = q ? {r[3:0], dq_in} : {r[6:0], dq_in[1]};
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  // Whole frame; every edge follows a bench clock edge
  task automatic fr(input logic [4:0] qm, input int n,
                    input logic [39:0] b, output logic [7:0] r);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < n; k++) xb(b[39-8*k -: 8], qm[k], r);
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    dq <= ~dq; // Released lines must not keep the last value
    repeat (30) @(posedge clk);
  endtask
endmodule

// file: test/serial_flash_mode_control_tb.sv
// Self-checking bench for the serial flash mode control block
`timescale 1ns/1ps
`include "sfmc_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================
// Bench
module serial_flash_mode_control_tb;
  logic clk, rst_n, psel, pen, pwr, sck, cs_n, pready, pslverr, qm, cr, a4;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] dq_o, dq_oe, hdq, dq_w;
  logic [7:0] r;
  int fails = 0, checks_done = 0, cyc = 0;
  // The block wins on every line it drives
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & hdq);
  serial_flash_mode_control serial_flash_mode_control_inst (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
    .SPI_DQ_I(dq_w), .SPI_DQ_O(dq_o), .SPI_DQ_OE_O(dq_oe), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
    .QUAD_CMD_MODE_O(qm), .CONT_READ_O(cr), .ADDR4_MODE_O(a4));
  sfmc_host sfmc_host_inst (.clk(clk), .dq_in(dq_w), .sck(sck),
    .cs_n(cs_n), .dq(hdq));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic fr(input logic [4:0] m, input int n, input logic [39:0] b);
    sfmc_host_inst.fr(m, n, b, r);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_boot();
    apb(1'b0, `SFMC_STAT_OFS, 32'h0);
    `CHK(d[2:0], 3'h0)
    apb(1'b1, `SFMC_CFG3_OFS, 32'hFF);
    apb(1'b0, `SFMC_CFG3_OFS, 32'h0);
    `CHK(d, 32'h0)
  endtask
  task automatic t_qe();
    for (int i = 0; i < 2; i++) begin
      fr(5'h0, 3, {8'h01, 8'h1C, i ? 8'h00 : 8'h02, 16'h0});
      fr(5'h0, 2, {8'h35, 32'h0});
      `CHK(r, i ? 8'h00 : 8'h02)
      apb(1'b0, `SFMC_SR2_OFS, 32'h0);
      `CHK(d[1], ~i[0])
    end
    fr(5'h0, 2, {8'h05, 32'h0});
    `CHK(r, 8'h1C)
    apb(1'b0, `SFMC_SR1_OFS, 32'h0);
    `CHK(d[7:0], 8'h1C)
  endtask
  task automatic t_cont();
    fr(5'h1E, 5, {8'hEB, 24'h0, 8'hA5});
    `CHK(cr, 1'b0)
    fr(5'h0, 3, {8'h01, 8'h00, 8'h02, 16'h0});
    for (int i = 0; i < 2; i++) begin
      fr(5'h1E, 5, {8'hEB, 24'h0, i ? 8'hA3 : 8'hA5});
      `CHK(cr, 1'b1)
      fr(5'h0F, 4, {24'h10, 8'hA5, 8'h0});
      `CHK(cr, 1'b1)
      if (i == 0) fr(5'h0F, 4, {24'h20, 8'h00, 8'h0});
      else fr(5'h0F, 4, {32'hFFFFFFFF, 8'h0});
      `CHK(cr, 1'b0)
    end
    // Fourth byte is still address, so no mode byte is seen
    fr(5'h1E, 5, {8'hEC, 32'hA5A5A5A5});
    `CHK(cr, 1'b0)
  endtask
  task automatic t_qpi();
    fr(5'h0, 5, {8'h65, 24'h800003, 8'h00});
    `CHK(r, 8'h00)
    fr(5'h0, 5, {8'h71, 24'h800003, 8'h40});
    `CHK(qm, 1'b1)
    apb(1'b0, `SFMC_CFG3_OFS, 32'h0);
    `CHK(d[6], 1'b1)
    fr(5'h1F, 5, {8'h65, 24'h800003, 8'h00});
    `CHK(r, 8'h40)
    fr(5'h1F, 5, {8'h71, 24'h800003, 8'h00});
    `CHK(qm, 1'b0)
    fr(5'h0, 5, {8'h71, 24'h800003, 8'h40});
    `CHK(qm, 1'b1)
    fr(5'h1F, 1, {8'h66, 32'h0});
    fr(5'h1F, 1, {8'h99, 32'h0});
    `CHK(qm, 1'b0)
  endtask
  task automatic t_addr4();
    fr(5'h0, 1, {8'hB7, 32'h0});
    `CHK(a4, 1'b1)
    // Four address bytes now, so the last A5h is not a mode byte
    fr(5'h1E, 5, {8'hEB, 32'hA5A5A5A5});
    `CHK(cr, 1'b0)
    fr(5'h0, 1, {8'h66, 32'h0});
    fr(5'h0, 1, {8'h99, 32'h0});
    `CHK(a4, 1'b0)
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_qe();
    t_cont();
    t_qpi();
    t_addr4();
    results();
  end
endmodule
